// *** hw/srbp_pkg.sv ***
package srbp_pkg;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 16;
  localparam logic [13:0] ADDR_CTRL = 14'h0000;
  localparam logic [13:0] ADDR_MODE = 14'h0001;
  localparam logic [13:0] ADDR_SRST = 14'h0002;
  localparam logic [13:0] ADDR_OEN = 14'h0003;
  localparam int unsigned CTRL_BPE_BIT = 13;
  localparam int unsigned MODE_START_BIT = 0;
  localparam int unsigned MODE_PAT_LSB = 1;
  localparam int unsigned PAT_W = 3;
  localparam int unsigned SRST_PLL_BIT = 0;
  localparam int unsigned SRST_SW_BIT = 1;
  localparam int unsigned OEN_W = 9;
  localparam int unsigned NUM_CLK_OUT = 6;
  localparam int unsigned NUM_FRM_OUT = 7;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] SRST_RST = 16'h0000;
  localparam logic [8:0] OEN_RST = 9'h000;
  localparam int unsigned CM_ADDR_W = 11;
  localparam int unsigned CM_DEPTH = 2048;
  localparam int unsigned FRAME_CYCLES = 5000;
  localparam int unsigned PROG_LIMIT = 2 * FRAME_CYCLES;
  typedef enum logic [1:0] {
    SRBP_IDLE = 2'b01,
    SRBP_LOAD = 2'b10
  } srbp_state_t;
endpackage

// *** hw/srbp_ctrl.sv ***
`timescale 1ns/1ps
// Function
// RULE_01: Writing start bit one begins block programming
// RULE_02: Host keeps other mode bits unchanged
// RULE_03: Clearing start or enable aborts programming
// RULE_04: Host writes zero to unused reset bits
// RULE_05: Bit 1 holds switching blocks in reset
// RULE_06: Bit 0 holds the DPLL in reset
// RULE_07: Enable register holds nine bits, rest zero
// RULE_08: Programming finishes within two frames
// RULE_09: Pattern into low words, everything else zeroed
// RULE_10: Enable bit drives output, clear means hi-z
module srbp_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [13:0] addr,
  input wire logic cs,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  input wire logic [5:0] clk_out_val,
  input wire logic [6:0] frm_out_val,
  output logic [5:0] clk_out_o,
  output logic [5:0] clk_out_oe_n,
  output logic [6:0] frm_out_o,
  output logic [6:0] frm_out_oe_n,
  output logic switch_soft_reset,
  output logic pll_soft_reset,
  output logic prog_busy,
  output logic cm_we,
  output logic [10:0] cm_addr,
  output logic [15:0] cm_low_data,
  output logic [15:0] cm_high_data
);
  logic [15:0] ctrl_q, ctrl_d, mode_q, mode_d, srst_q, srst_d;
  logic [8:0] oen_q, oen_d;
  logic [15:0] rdata_d;
  srbp_pkg::srbp_state_t st_q, st_d;
  logic [10:0] ptr_q, ptr_d;
  logic we_d;
  logic wr_en;
  logic [5:0] clk_en;
  logic [6:0] frm_en;
  logic [15:0] low_d;
  logic busy_d;
  logic [5:0] clk_oe_n_d;
  logic [6:0] frm_oe_n_d;
  logic [15:0] load_cnt_q, load_cnt_d;

  assign wr_en = cs && wr;

  always_comb begin
    ctrl_d = ctrl_q;
    mode_d = mode_q;
    srst_d = srst_q;
    oen_d = oen_q;
    rdata_d = rdata;
    if (wr_en) begin
      case (addr)
        srbp_pkg::ADDR_CTRL: ctrl_d = wdata;
        srbp_pkg::ADDR_MODE: mode_d = wdata;
        srbp_pkg::ADDR_SRST: srst_d = {14'h0000, wdata[1:0]};
        srbp_pkg::ADDR_OEN: oen_d = wdata[8:0]; // [RULE_07]
        default: ;
      endcase
    end
    if (cs && rd) begin
      case (addr)
        srbp_pkg::ADDR_CTRL: rdata_d = ctrl_q;
        srbp_pkg::ADDR_MODE: rdata_d = mode_q;
        srbp_pkg::ADDR_SRST: rdata_d = srst_q;
        srbp_pkg::ADDR_OEN: rdata_d = {7'h00, oen_q}; // [RULE_07]
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // Programming engine: one word per cycle, 2048 cycles well inside two frames
  always_comb begin
    st_d = st_q;
    ptr_d = ptr_q;
    we_d = 1'b0;
    case (st_q)
      srbp_pkg::SRBP_IDLE: begin
        // Rising edge of start with enable set begins a pass
        if (mode_d[srbp_pkg::MODE_START_BIT] &&
            !mode_q[srbp_pkg::MODE_START_BIT] &&
            ctrl_d[srbp_pkg::CTRL_BPE_BIT]) begin // [RULE_01]
          st_d = srbp_pkg::SRBP_LOAD;
          ptr_d = 11'h000;
        end
      end
      srbp_pkg::SRBP_LOAD: begin
        if (!mode_q[srbp_pkg::MODE_START_BIT] ||
            !ctrl_q[srbp_pkg::CTRL_BPE_BIT]) begin // [RULE_03]
          st_d = srbp_pkg::SRBP_IDLE;
        end else begin
          we_d = 1'b1;
          ptr_d = ptr_q + 11'h001;
          if (ptr_q == 11'(srbp_pkg::CM_DEPTH - 1)) begin // [RULE_08]
            st_d = srbp_pkg::SRBP_IDLE;
          end
        end
      end
      default: st_d = srbp_pkg::SRBP_IDLE;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cf
      assign clk_en[g] = oen_q[g];
      assign frm_en[g] = oen_q[g];
    end
  endgenerate
  assign clk_en[5:4] = oen_q[5:4];
  assign frm_en[6:4] = oen_q[8:6];

  // Output next values; the flops below only register them
  always_comb begin
    low_d = {13'h0000,
             mode_q[srbp_pkg::MODE_PAT_LSB +: srbp_pkg::PAT_W]}; // [RULE_09]
    busy_d = (st_d == srbp_pkg::SRBP_LOAD);
    clk_oe_n_d = ~clk_en; // [RULE_10]
    frm_oe_n_d = ~frm_en; // [RULE_10]
    load_cnt_d = (st_q == srbp_pkg::SRBP_LOAD) ?
                 load_cnt_q + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= srbp_pkg::CTRL_RST;
      mode_q <= srbp_pkg::MODE_RST;
      srst_q <= srbp_pkg::SRST_RST;
      oen_q <= srbp_pkg::OEN_RST;
      rdata <= 16'h0000;
      st_q <= srbp_pkg::SRBP_IDLE;
      ptr_q <= 11'h000;
      cm_we <= 1'b0;
      cm_addr <= 11'h000;
      cm_low_data <= 16'h0000;
      cm_high_data <= 16'h0000;
      prog_busy <= 1'b0;
      switch_soft_reset <= 1'b0;
      pll_soft_reset <= 1'b0;
      clk_out_o <= 6'h00;
      clk_out_oe_n <= 6'h3f;
      frm_out_o <= 7'h00;
      frm_out_oe_n <= 7'h7f;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      srst_q <= srst_d;
      oen_q <= oen_d;
      rdata <= rdata_d;
      st_q <= st_d;
      ptr_q <= ptr_d;
      cm_we <= we_d; // [RULE_03]
      cm_addr <= ptr_q;
      cm_low_data <= low_d; // [RULE_09]
      cm_high_data <= 16'h0000; // [RULE_09]
      prog_busy <= busy_d;
      switch_soft_reset <= srst_d[srbp_pkg::SRST_SW_BIT]; // [RULE_05]
      pll_soft_reset <= srst_d[srbp_pkg::SRST_PLL_BIT]; // [RULE_06]
      clk_out_o <= clk_out_val;
      frm_out_o <= frm_out_val;
      clk_out_oe_n <= clk_oe_n_d; // [RULE_10]
      frm_out_oe_n <= frm_oe_n_d; // [RULE_10]
    end
  end

  // Cycles spent loading; a pass is far shorter than two frames
  always_ff @(posedge clk) begin
    if (rst) load_cnt_q <= 16'h0000;
    else if (ce) load_cnt_q <= load_cnt_d;
  end

  sw_reset_a: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
    ce && wr_en && addr == srbp_pkg::ADDR_SRST |=> switch_soft_reset ==
    $past(wdata[1])) else $error("switch reset mismatch");
  pll_reset_a: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
    ce && wr_en && addr == srbp_pkg::ADDR_SRST |=> pll_soft_reset ==
    $past(wdata[0])) else $error("pll reset mismatch");
  oen_read_a: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
    ce && cs && rd && !wr && addr == srbp_pkg::ADDR_OEN |=>
    rdata[15:9] == 7'h00) else $error("enable upper bits not zero");
  prog_start_a: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
    ce && st_q == srbp_pkg::SRBP_IDLE && wr_en && addr ==
    srbp_pkg::ADDR_MODE && wdata[0] && !mode_q[0] && ctrl_q[13] |=>
    st_q == srbp_pkg::SRBP_LOAD) else $error("programming did not start");
  prog_abort_a: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
    ce && st_q == srbp_pkg::SRBP_LOAD && !mode_q[0] |=>
    st_q == srbp_pkg::SRBP_IDLE) else $error("abort ignored");
  prog_bound_a: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
    load_cnt_q <= 16'd2049) else $error("programming too long");
  cm_data_a: assert property (@(posedge clk) disable iff (rst) // [RULE_09]
    cm_we |-> cm_high_data == 16'h0000 && cm_low_data[15:3] == 13'h0000)
    else $error("memory word not cleared");
  out_hiz_a: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
    ce && !oen_q[0] |=> clk_out_oe_n[0] && frm_out_oe_n[0])
    else $error("disabled output driven");
  oen_map_a: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
    ce |=> clk_out_oe_n[5] == !$past(oen_q[5]) &&
    frm_out_oe_n[6] == !$past(oen_q[8])) else $error("enable map wrong");
  bpe_abort_a: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
    ce && st_q == srbp_pkg::SRBP_LOAD && !ctrl_q[srbp_pkg::CTRL_BPE_BIT] |=>
    st_q == srbp_pkg::SRBP_IDLE && !cm_we) else $error("enable abort ignored");
  idle_quiet_a: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
    ce && st_q == srbp_pkg::SRBP_IDLE |=> !cm_we)
    else $error("memory written while idle");
  prog_step_a: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
    ce && st_q == srbp_pkg::SRBP_LOAD && mode_q[0] && ctrl_q[13] |=>
    cm_we && cm_addr == $past(ptr_q)) else $error("word not loaded");
  prog_pat_a: assert property (@(posedge clk) disable iff (rst) // [RULE_09]
    ce && st_q == srbp_pkg::SRBP_LOAD |=>
    cm_low_data[2:0] == $past(mode_q[3:1])) else $error("pattern wrong");
  srst_read_a: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
    ce && cs && rd && !wr && addr == srbp_pkg::ADDR_SRST |=>
    rdata[15:2] == 14'h0000) else $error("reset upper bits not zero");
  ce_freeze_a: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
    !ce |=> $stable(st_q) && $stable(ptr_q) && $stable(cm_we) &&
    $stable(oen_q)) else $error("state moved while frozen");
  prog_done_c: cover property (@(posedge clk)
    st_q == srbp_pkg::SRBP_LOAD && ptr_q == 11'h7ff);
  prog_abort_c: cover property (@(posedge clk)
    st_q == srbp_pkg::SRBP_LOAD && !mode_q[0]);
  sw_reset_c: cover property (@(posedge clk) $rose(switch_soft_reset));
  ce_freeze_c: cover property (@(posedge clk)
    st_q == srbp_pkg::SRBP_LOAD && !ce);
  bpe_abort_c: cover property (@(posedge clk)
    st_q == srbp_pkg::SRBP_LOAD && !ctrl_q[srbp_pkg::CTRL_BPE_BIT]);
endmodule

// *** tb/srbp_host.sv ***
`timescale 1ns/1ps
module srbp_host (
  input wire logic clk,
  output logic [13:0] addr,
  output logic cs,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  initial begin
    {addr, cs, wr, rd, wdata} = '0;
  end
  // Released data shows the inverse, never a stale copy
  task automatic wr_reg(logic [13:0] a, logic [15:0] d);
    @(negedge clk);
    {addr, wdata, cs, wr} = {a, d, 2'b11};
    @(negedge clk);
    {cs, wr, wdata} = {2'b00, ~d};
  endtask
  task automatic rd_reg(logic [13:0] a, output logic [15:0] d);
    @(negedge clk);
    {addr, cs, rd} = {a, 2'b11};
    @(negedge clk);
    {cs, rd} = 2'b00;
    @(negedge clk);
    d = rdata;
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, ce = 1, cs, wr, rd, ssr, psr, busy, we;
  logic [13:0] addr;
  logic [15:0] wdata, rdata, rv, cl, ch, e, lf = 16'h003c, pat;
  logic [5:0] cv = 0, co, coe;
  logic [6:0] fv = 0, fo, foe;
  logic [10:0] ca;
  logic ce_s = 0;
  logic [15:0] mdl [8] = '{default: 16'h0000};
  int mismatches = 0, num_checks = 0, cyc = 0, nw = 0, n1;
  initial forever #12.5 clk = ~clk;
  srbp_host host(.clk(clk), .addr(addr), .cs(cs), .wr(wr), .rd(rd),
    .wdata(wdata), .rdata(rdata));
  srbp_ctrl uut(.clk(clk), .rst(rst), .ce(ce), .addr(addr), .cs(cs),
    .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .clk_out_val(cv),
    .frm_out_val(fv), .clk_out_o(co), .clk_out_oe_n(coe), .frm_out_o(fo),
    .frm_out_oe_n(foe), .switch_soft_reset(ssr), .pll_soft_reset(psr),
    .prog_busy(busy), .cm_we(we), .cm_addr(ca), .cm_low_data(cl),
    .cm_high_data(ch));
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(logic [15:0] g, logic [15:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic put(logic [13:0] a, logic [15:0] d);
    host.wr_reg(a, d);
    case (a)
      14'h0000, 14'h0001: mdl[a[2:0]] = d;
      14'h0002: mdl[a[2:0]] = d & 16'h0003;
      14'h0003: mdl[a[2:0]] = d & 16'h01ff;
      default: ;
    endcase
  endtask
  task automatic get(logic [13:0] a);
    host.rd_reg(a, rv);
    chk(rv, (a < 14'h0008) ? mdl[a[2:0]] : 16'h0000);
  endtask
  always @(posedge clk) ce_s <= ce;
  // Count only words launched at an enabled edge; frozen outputs repeat
  always @(negedge clk) if (we === 1'b1 && ce_s) begin
    chk(16'(ca), 16'(nw));
    chk(cl, {13'h0, pat[2:0]});
    chk(ch, 16'h0000);
    nw++;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    get(14'h0002);
    chk(16'(coe), 16'h003f);
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      put(14'h0002, {14'h0, lf[1:0]});
      put(14'h0003, lf);
      {cv, fv} = lf[12:0] ^ lf[15:3];
      put(14'h0005, lf);
      repeat (2) @(negedge clk);
      chk(16'({ssr, psr}), 16'(lf[1:0]));
      e = lf & 16'h01ff;
      chk(16'(coe), {10'h000, ~e[5:0]});
      chk(16'(foe), {9'h000, ~{e[8:6], e[3:0]}});
      chk(16'(co & e[5:0]), 16'(cv & e[5:0]));
      chk(16'(fo & {e[8:6], e[3:0]}), 16'(fv & {e[8:6], e[3:0]}));
      get(14'h0003);
      get(14'h0005);
      get(14'h0002);
    end
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    foreach (mdl[j]) mdl[j] = 16'h0000;
    chk(16'({ssr, psr, coe}), 16'h003f);
    get(14'h0003);
    for (int k = 0; k < 3; k++) begin
      lf = nxt(lf);
      pat = lf;
      nw = 0;
      put(14'h0001, 16'h0000);
      put(14'h0000, 16'h2000);
      put(14'h0001, {12'h0, pat[2:0], 1'b1});
      repeat (100) @(negedge clk);
      if (k == 0) begin
        put(14'h0001, {12'h0, pat[2:0], 1'b1});
        ce = 0;
        @(negedge clk);
        n1 = nw;
        repeat (20) @(negedge clk);
        chk(16'(nw), 16'(n1));
        chk(16'(busy), 16'h0001);
        ce = 1;
        repeat (2000) @(negedge clk);
      end
      if (k == 1) put(14'h0001, {12'h0, pat[2:0], 1'b0});
      if (k == 2) put(14'h0000, 16'h0000);
      repeat (4) @(negedge clk);
      n1 = nw;
      repeat (40) @(negedge clk);
      chk(16'(nw), k == 0 ? 16'd2048 : 16'(n1));
      if (k > 0 && nw >= 2048) chk(16'(nw), 16'd0);
      chk(16'(busy), 16'h0000);
      get(14'h0001);
    end
    give_verdict();
  end
endmodule
